// file: logic/scc_pkg.sv
// Package: register map, field positions and carrier types of the serial control slice
package scc_pkg;
  localparam logic [11:0] SCC_OFF_CONTROL = 12'h000;
  localparam logic [11:0] SCC_OFF_MODE = 12'h004;
  localparam logic [11:0] SCC_OFF_STATUS = 12'h008;
  localparam logic [11:0] SCC_OFF_IRQ_STAT = 12'h00C;
  localparam logic [11:0] SCC_OFF_IRQ_MASK = 12'h010;
  localparam int SCC_ADDR_W = 12;
  localparam logic [7:0] SCC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SCC_MODE_RESET = 8'h00;
  localparam logic [3:0] SCC_IRQ_MASK_RESET = 4'h0;
  localparam int SCC_BIT_TIE = 7;
  localparam int SCC_BIT_RIE = 6;
  localparam int SCC_BIT_TXEN = 5;
  localparam int SCC_BIT_RXEN = 4;
  localparam int SCC_BIT_MPW = 3;
  localparam int SCC_BIT_TX_END_IRQ_EN = 2;
  localparam int SCC_MODE_BIT_SYNC = 7;
  localparam int SCC_MODE_BIT_MP = 2;
  localparam logic [1:0] SCC_CLK_INT = 2'b00;
  localparam logic [1:0] SCC_CLK_INT_OUT = 2'b01;
  localparam logic [1:0] SCC_CLK_EXT = 2'b10;
  localparam int SCC_EXT_OVERSAMPLE = 16;
  // Events of the interrupt status register
  localparam int SCC_EV_TXE = 0;
  localparam int SCC_EV_RXF = 1;
  localparam int SCC_EV_RXERR = 2;
  localparam int SCC_EV_TXEND = 3;
  typedef struct packed {
    logic tx_empty_irq_en;
    logic rx_irq_en;
    logic tx_enable;
    logic rx_enable;
    logic multiproc_wait_en;
    logic tx_end_irq_en;
    logic clk_select_hi;
    logic clk_select_lo;
  } scc_control_t;
  typedef struct packed {
    logic valid;
    logic mp_bit;
    logic framing_err;
    logic overrun_err;
  } scc_rx_char_t;
  typedef struct packed {
    logic use_internal;
    logic pin_out_bitclk;
    logic pin_out_xfer;
    logic pin_is_input;
  } scc_clk_route_t;
endpackage

// file: logic/scc_clk_route.sv
// Clock source and serial clock pin direction decode
`timescale 1ns/1ns
`default_nettype none
module scc_clk_route
  import scc_pkg::*;
(
  input wire logic i_sync_mode,
  input wire logic [1:0] i_clk_sel,
  output scc_clk_route_t o_route
);
  wire logic async_mode;
  assign async_mode = !i_sync_mode;
  // Reserved codes fall to the internal source with the pin released
  assign o_route.use_internal = (i_clk_sel != SCC_CLK_EXT);
  assign o_route.pin_out_bitclk = async_mode && (i_clk_sel == SCC_CLK_INT_OUT);
  assign o_route.pin_out_xfer = i_sync_mode && (i_clk_sel == SCC_CLK_INT);
  assign o_route.pin_is_input = (i_clk_sel == SCC_CLK_EXT);
endmodule
`default_nettype wire

// file: logic/scc_irq_gate.sv
// Sticky interrupt status with read clear and mask
`timescale 1ns/1ns
`default_nettype none
module scc_irq_gate
  import scc_pkg::*;
#(
  parameter int N = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [N-1:0] i_event,
  input wire logic i_clear,
  input wire logic [N-1:0] i_mask,
  output logic [N-1:0] o_status,
  output logic o_irq
);
  logic [N-1:0] status_reg;
  logic irq_reg;
  wire logic [N-1:0] status_next;
  initial begin
    if (N < 1) $error("N must be positive");
  end
  // Set wins over the read clear so no event is lost
  assign status_next = (i_clear ? '0 : status_reg) | i_event;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= |(status_next & i_mask);
    end
  end
  assign o_status = status_reg;
  assign o_irq = irq_reg;
endmodule
`default_nettype wire

// file: logic/scc_top.sv
// Serial control register slice: enables, interrupt gating, multiprocessor wait, clock select
`timescale 1ns/1ns
`default_nettype none
// Function
// - Bit 7 gates transmit-empty request
// - Bit 6 gates receive-full and error requests
// - Bit 5 enables transmitter
// - Bit 4 enables receiver
// - Wait bit only in async multiprocessor mode
// - Waiting: drop characters with mp bit 0
// - Mp bit 1 clears wait, resumes
// - Bit 2 gates transmit-end request
// - Async 00: internal clock, pin idle
// - Async 01: internal, bit clock out
// - Async external: pin gives 16x clock
// - Sync 00: internal, pin drives clock
// - Sync external: pin is clock input
// - Mode bit picks async or sync
// - Transmitter off holds empty, end set
// - Receiver off keeps stored mp bit
module scc_top
  import scc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SCC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire scc_rx_char_t i_rx_char,
  input wire logic i_tx_load,
  input wire logic i_tx_last_bit,
  input wire logic i_tdr_write,
  input wire logic i_baud_tick,
  input wire logic i_serial_clock_pin_in,
  output logic o_serial_clock_pin_out,
  output logic o_serial_clock_pin_oe_n,
  output logic o_tx_enable,
  output logic o_rx_enable,
  output logic o_engine_clk_ext,
  output logic o_tx_empty_flag,
  output logic o_tx_end_flag,
  output logic o_rx_full_flag,
  output logic o_framing_err_flag,
  output logic o_overrun_err_flag,
  output logic o_rx_multiproc_bit,
  output logic o_tx_empty_irq,
  output logic o_rx_full_irq,
  output logic o_rx_error_irq,
  output logic o_tx_end_irq,
  output logic o_irq
);
  scc_control_t ctrl_reg, ctrl_next;
  logic [7:0] mode_reg;
  logic [3:0] mask_reg;
  logic txe_reg, tx_end_flag_reg, rx_full_flag_reg, fer_reg, oer_reg, rx_multiproc_bit_reg;
  logic pin_out_reg, pin_oe_n_reg, ext_reg;
  logic txi_reg, rxi_reg, eri_reg, tei_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic pready_reg;
  scc_clk_route_t route;
  logic [3:0] irq_status;
  wire logic wr_acc, rd_acc, sel_ctrl, sel_mode, sel_stat, sel_istat, sel_imask, mapped;
  wire logic sync_mode, mp_mode, wait_active, rx_take, rx_accept, rx_drop;
  wire logic [3:0] events;
  wire logic [31:0] rd_mux;

  // One wait state keeps pready and prdata registered: read data and the read clear are
  // taken at the first access edge, a write lands at the edge where pready is high
  assign wr_acc = psel && penable && pwrite && pready_reg;
  assign rd_acc = psel && penable && !pwrite && !pready_reg;
  assign sel_ctrl = (paddr == SCC_OFF_CONTROL);
  assign sel_mode = (paddr == SCC_OFF_MODE);
  assign sel_stat = (paddr == SCC_OFF_STATUS);
  assign sel_istat = (paddr == SCC_OFF_IRQ_STAT);
  assign sel_imask = (paddr == SCC_OFF_IRQ_MASK);
  assign mapped = sel_ctrl | sel_mode | sel_stat | sel_istat | sel_imask;

  assign sync_mode = mode_reg[SCC_MODE_BIT_SYNC];
  assign mp_mode = mode_reg[SCC_MODE_BIT_MP];
  assign wait_active = ctrl_reg.multiproc_wait_en && mp_mode && !sync_mode;
  assign rx_take = i_rx_char.valid && ctrl_reg.rx_enable;
  assign rx_drop = rx_take && wait_active && !i_rx_char.mp_bit;
  assign rx_accept = rx_take && !rx_drop;

  // Wait bit self-clears on an address character; hardware clear beats a software write
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_acc && sel_ctrl) begin
      ctrl_next = scc_control_t'(pwdata[7:0]);
    end
    if (rx_take && wait_active && i_rx_char.mp_bit) begin
      ctrl_next.multiproc_wait_en = 1'b0;
    end
  end

  assign rd_mux = sel_ctrl ? {24'h00_0000, ctrl_reg} :
                  sel_mode ? {24'h00_0000, mode_reg} :
                  sel_stat ? {24'h00_0000, txe_reg, rx_full_flag_reg, oer_reg, fer_reg, 1'b0,
                              tx_end_flag_reg, rx_multiproc_bit_reg, 1'b0} :
                  sel_istat ? {28'h000_0000, irq_status} :
                  sel_imask ? {28'h000_0000, mask_reg} : 32'h0000_0000;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= SCC_CONTROL_RESET;
      mode_reg <= SCC_MODE_RESET;
      mask_reg <= SCC_IRQ_MASK_RESET;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      if (wr_acc && sel_mode) mode_reg <= pwdata[7:0];
      if (wr_acc && sel_imask) mask_reg <= pwdata[3:0];
      prdata_reg <= rd_acc ? rd_mux : 32'h0000_0000;
      // Unmapped addresses read zero and ignore writes; no error is signalled
      pslverr_reg <= 1'b0;
      pready_reg <= psel && penable && !pready_reg;
    end
  end

  // Transmit flags: held set while the transmitter is off
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      txe_reg <= 1'b1;
      tx_end_flag_reg <= 1'b1;
    end else if (!ctrl_reg.tx_enable) begin
      txe_reg <= 1'b1;
      tx_end_flag_reg <= 1'b1;
    end else begin
      txe_reg <= i_tx_load | (txe_reg & !i_tdr_write);
      tx_end_flag_reg <= (i_tx_last_bit & txe_reg) | (tx_end_flag_reg & !i_tdr_write);
    end
  end

  // Receive flags: set only for accepted characters, cleared only by reset; the mp bit is loaded for every enabled character
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_full_flag_reg <= 1'b0;
      fer_reg <= 1'b0;
      oer_reg <= 1'b0;
      rx_multiproc_bit_reg <= 1'b0;
    end else begin
      if (rx_accept) rx_full_flag_reg <= 1'b1;
      if (rx_accept && i_rx_char.framing_err) fer_reg <= 1'b1;
      if (rx_accept && i_rx_char.overrun_err) oer_reg <= 1'b1;
      if (rx_take) rx_multiproc_bit_reg <= i_rx_char.mp_bit;
    end
  end

  scc_clk_route u_route (
    .i_sync_mode(sync_mode),
    .i_clk_sel({ctrl_reg.clk_select_hi, ctrl_reg.clk_select_lo}),
    .o_route(route)
  );

  // Pin drive; the baud tick stands in for the bit clock at this slice's boundary
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_out_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
      ext_reg <= 1'b0;
    end else begin
      pin_out_reg <= (route.pin_out_bitclk | route.pin_out_xfer) ? i_baud_tick : 1'b0;
      pin_oe_n_reg <= !(route.pin_out_bitclk | route.pin_out_xfer);
      ext_reg <= route.pin_is_input;
    end
  end

  assign events[SCC_EV_TXE] = txe_reg & ctrl_reg.tx_empty_irq_en;
  assign events[SCC_EV_RXF] = rx_full_flag_reg & ctrl_reg.rx_irq_en;
  assign events[SCC_EV_RXERR] = (fer_reg | oer_reg) & ctrl_reg.rx_irq_en;
  assign events[SCC_EV_TXEND] = tx_end_flag_reg & ctrl_reg.tx_end_irq_en;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      txi_reg <= 1'b0;
      rxi_reg <= 1'b0;
      eri_reg <= 1'b0;
      tei_reg <= 1'b0;
    end else begin
      txi_reg <= events[SCC_EV_TXE];
      rxi_reg <= events[SCC_EV_RXF];
      eri_reg <= events[SCC_EV_RXERR];
      tei_reg <= events[SCC_EV_TXEND];
    end
  end

  scc_irq_gate #(.N(4)) u_irq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_event(events),
    .i_clear(rd_acc && sel_istat),
    .i_mask(mask_reg),
    .o_status(irq_status),
    .o_irq(o_irq)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign o_serial_clock_pin_out = pin_out_reg;
  assign o_serial_clock_pin_oe_n = pin_oe_n_reg;
  assign o_tx_enable = ctrl_reg.tx_enable;
  assign o_rx_enable = ctrl_reg.rx_enable;
  assign o_engine_clk_ext = ext_reg;
  assign o_tx_empty_flag = txe_reg;
  assign o_tx_end_flag = tx_end_flag_reg;
  assign o_rx_full_flag = rx_full_flag_reg;
  assign o_framing_err_flag = fer_reg;
  assign o_overrun_err_flag = oer_reg;
  assign o_rx_multiproc_bit = rx_multiproc_bit_reg;
  assign o_tx_empty_irq = txi_reg;
  assign o_rx_full_irq = rxi_reg;
  assign o_rx_error_irq = eri_reg;
  assign o_tx_end_irq = tei_reg;

  a_txi_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tx_empty_irq |-> $past(ctrl_reg.tx_empty_irq_en)) else $error("tx empty irq ungated");
  a_rxi_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_rx_full_irq || o_rx_error_irq) |-> $past(ctrl_reg.rx_irq_en))
    else $error("rx irq ungated");
  a_tei_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tx_end_irq |-> $past(ctrl_reg.tx_end_irq_en)) else $error("tx end irq ungated");
  a_tx_off_flags: assert property (@(posedge i_clk) disable iff (i_rst)
    !ctrl_reg.tx_enable |=> (o_tx_empty_flag && o_tx_end_flag)) else $error("tx flags not held");
  a_mp_drop: assert property (@(posedge i_clk) disable iff (i_rst)
    (rx_drop && !rx_full_flag_reg) |=> !o_rx_full_flag) else $error("dropped char set flag");
  a_mp_resume: assert property (@(posedge i_clk) disable iff (i_rst)
    (rx_take && wait_active && i_rx_char.mp_bit) |=> (!ctrl_reg.multiproc_wait_en && o_rx_full_flag))
    else $error("wait not cleared");
  a_rx_multiproc_bit_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !ctrl_reg.rx_enable |=> $stable(o_rx_multiproc_bit)) else $error("mp bit changed");
  a_sync_pin_out: assert property (@(posedge i_clk) disable iff (i_rst)
    (sync_mode && {ctrl_reg.clk_select_hi, ctrl_reg.clk_select_lo} == SCC_CLK_INT)
    |=> !o_serial_clock_pin_oe_n) else $error("sync pin not driven");
  a_ext_pin_in: assert property (@(posedge i_clk) disable iff (i_rst)
    ({ctrl_reg.clk_select_hi, ctrl_reg.clk_select_lo} == SCC_CLK_EXT)
    |=> (o_serial_clock_pin_oe_n && o_engine_clk_ext)) else $error("ext pin driven");
endmodule
`default_nettype wire

// file: test/scc_remote.sv
// Far-side serial device: received characters and the clock it feeds into the pin
`timescale 1ns/1ns
`default_nettype none
module scc_remote
  import scc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_send,
  input wire logic [2:0] i_bits,
  input wire logic i_pin_oe_n,
  input wire logic i_ext,
  output scc_rx_char_t o_rx_char,
  output logic o_pin
);
  logic [2:0] div_reg = 3'h0;
  initial o_rx_char = '0;
  initial o_pin = 1'b0;
  always @(posedge i_clk) begin
    o_rx_char <= {i_send, i_bits};
    div_reg <= div_reg + 3'h1;
    // A slow clock only while the pin is ours; otherwise a pattern no stale value hides in
    if (i_ext && i_pin_oe_n) begin
      if (div_reg == 3'h7) o_pin <= ~o_pin;
    end else begin
      o_pin <= ~o_pin;
    end
  end
endmodule
`default_nettype wire

// file: test/scc_top_bench.sv
// Self-checking bench of the serial control slice
`timescale 1ns/1ns
`default_nettype none
module scc_top_bench
  import scc_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, baud, pin, send;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] txp, bits;
  scc_rx_char_t rxc;
  logic pout, oen, txen, rxen, ext, txef, tendf, rxff, ferf, oerf, mpb, tx_empty_irq, rx_full_irq, rx_error_irq, tx_end_irq, irq;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  scc_top dut (
    .i_clk(clk), .i_rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_rx_char(rxc), .i_tx_load(txp[1]), .i_tx_last_bit(txp[0]), .i_tdr_write(txp[2]),
    .i_baud_tick(baud), .i_serial_clock_pin_in(pin), .o_serial_clock_pin_out(pout),
    .o_serial_clock_pin_oe_n(oen), .o_tx_enable(txen), .o_rx_enable(rxen),
    .o_engine_clk_ext(ext), .o_tx_empty_flag(txef), .o_tx_end_flag(tendf),
    .o_rx_full_flag(rxff), .o_framing_err_flag(ferf), .o_overrun_err_flag(oerf),
    .o_rx_multiproc_bit(mpb), .o_tx_empty_irq(tx_empty_irq), .o_rx_full_irq(rx_full_irq),
    .o_rx_error_irq(rx_error_irq), .o_tx_end_irq(tx_end_irq), .o_irq(irq)
  );
  scc_remote remote (.i_clk(clk), .i_send(send), .i_bits(bits), .i_pin_oe_n(oen),
    .i_ext(ext), .o_rx_char(rxc), .o_pin(pin));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held until pready is seen high at a rising edge; read data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic txpulse(input logic [2:0] p);
    @(posedge clk);
    txp <= p;
    @(posedge clk);
    txp <= 3'h0;
    settle(3);
  endtask
  task automatic rxsend(input logic [2:0] b);
    @(posedge clk);
    send <= 1'b1;
    bits <= b;
    @(posedge clk);
    send <= 1'b0;
    settle(3);
  endtask
  task automatic t_irq;
    rdc("irq status", SCC_OFF_IRQ_STAT, 32'h0000_0000);
    apb(1'b1, SCC_OFF_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, SCC_OFF_CONTROL, 32'h0000_0084);
    settle(3);
    chk("tx irqs", {tx_empty_irq, tx_end_irq, irq}, 3'h7);
    apb(1'b1, SCC_OFF_CONTROL, 32'h0000_0000);
    settle(3);
    chk("tx irqs off", {tx_empty_irq, tx_end_irq}, 2'h0);
    rdc("irq status", SCC_OFF_IRQ_STAT, 32'h0000_0009);
    rdc("irq cleared", SCC_OFF_IRQ_STAT, 32'h0000_0000);
    apb(1'b1, SCC_OFF_CONTROL, 32'h0000_0004);
    settle(3);
    chk("masked", {tx_end_irq, irq}, 2'h2);
  endtask
  task automatic t_tx;
    apb(1'b1, SCC_OFF_CONTROL, 32'h0000_00A4);
    txpulse(3'h4);
    chk("tx write", {txen, txef, tendf, tx_empty_irq, tx_end_irq}, 5'h10);
    txpulse(3'h2);
    chk("tx load", {txef, tendf, tx_empty_irq}, 3'h5);
    txpulse(3'h1);
    chk("tx end", {tendf, tx_end_irq}, 2'h3);
    txpulse(3'h4);
    apb(1'b1, SCC_OFF_CONTROL, 32'h0000_0000);
    txpulse(3'h4);
    chk("tx off", {txen, txef, tendf}, 3'h3);
  endtask
  task automatic t_rx;
    apb(1'b1, SCC_OFF_MODE, 32'h0000_0084);
    apb(1'b1, SCC_OFF_CONTROL, 32'h0000_0058);
    rxsend(3'h0);
    chk("sync rx", {rxen, rxff, rx_full_irq}, 3'h7);
    apb(1'b1, SCC_OFF_MODE, 32'h0000_0004);
    rxsend(3'h3);
    chk("skipped", {ferf, oerf}, 2'h0);
    rdc("wait held", SCC_OFF_CONTROL, 32'h0000_0058);
    rxsend(3'h4);
    rdc("wait cleared", SCC_OFF_CONTROL, 32'h0000_0050);
    apb(1'b1, SCC_OFF_CONTROL, 32'h0000_0040);
    rxsend(3'h3);
    chk("rx off", {rxen, ferf, mpb}, 3'h1);
    apb(1'b1, SCC_OFF_CONTROL, 32'h0000_0050);
    rxsend(3'h3);
    chk("rx errors", {ferf, oerf, rx_error_irq, mpb}, 4'hE);
    apb(1'b1, SCC_OFF_CONTROL, 32'h0000_0010);
    settle(3);
    chk("rx irqs off", {rx_full_irq, rx_error_irq}, 2'h0);
  endtask
  // Entries are {sync, code, pin released, external}; reserved codes are never written
  task automatic t_clk;
    logic [4:0] tab [5] = '{5'h02, 5'h04, 5'h0B, 5'h10, 5'h1B};
    foreach (tab[i]) begin
      apb(1'b1, SCC_OFF_MODE, {24'h00_0000, tab[i][4], 7'h00});
      apb(1'b1, SCC_OFF_CONTROL, {30'h0000_0000, tab[i][3:2]});
      settle(3);
      chk("clock route", {oen, ext, pout}, {tab[i][1:0], ~tab[i][1]});
    end
    apb(1'b1, 12'h020, 32'h0000_00FF);
    rdc("unmapped", 12'h020, 32'h0000_0000);
    rdc("control kept", SCC_OFF_CONTROL, 32'h0000_0002);
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    txp = 3'h0;
    bits = 3'h0;
    send = 1'b0;
    baud = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    chk("reset flags", {txef, tendf, oen}, 3'h7);
    rdc("control reset", SCC_OFF_CONTROL, 32'h0000_0000);
    t_irq;
    t_tx;
    t_rx;
    t_clk;
    report_and_stop;
  end
endmodule
`default_nettype wire
